// *** charger_mode_controller.sv ***
/*
 * Operating-mode controller of a single-cell linear charger with an
 * AHB-Lite register slave for variant straps and live status.
 * Assumes comparator results arrive asynchronously and that the
 * timer, termination and detection circuits latch their own results.
 */
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Charge starts: power, enable low, below recharge
// - Termination low enables end and absent detection
// - Power-good is open-collector, active low
// - Charge start runs enabled safety timer
// - Below precharge threshold select tenth current
// - Power-down: all off, all pins float
// - Sleep: charger off, status float, no power
// - Lost input power forces sleep unless below power-down
// - Power detected in sleep starts reset delay
// - During delay show charger off, no power
// - Delay end enables comparators and pins
// - Delay end with enable high gives standby
// - No enable pin: delay end begins charge
// - Begin-charge resets timers then charges
// - Temperature out of range suspends, timers held
// - Temperature back resumes from held counts
// - Timer pin open: no termination, timer reset
// - Status codes: precharge, fast, done
// - Standby resets timers, suspend holds them
// - Overvoltage gives standby, not latched
module charger_mode_controller #(
  parameter int POR_DELAY = charger_pkg::POR_CYCLES
) (
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_NRST,
  // Comparators and control pins
  input wire charger_pkg::pins_t I_PINS,
  // Analog controls and open-collector pins
  output charger_pkg::ctl_t O_CTL,
  // AHB-Lite slave
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP
);
  import charger_pkg::*;

  localparam int CNT_W = $clog2(POR_DELAY + 1);
  localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_DELAY - 1);

  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  pins_t pin_meta;
  pins_t pin;

  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      pin_meta <= '0;
      pin <= '0;
    end
    else
    begin
      pin_meta <= I_PINS;
      pin <= pin_meta;
    end
  end

  // ---------------------------------------------------------------
  // Mode sequencer
  // ---------------------------------------------------------------
  state_t state;
  state_t next_state;
  logic [CNT_W-1:0] por_cnt;
  logic [CNT_W-1:0] next_por_cnt;
  logic [1:0] ctrl;
  logic ce_present;
  logic temp_ok;
  logic charge_en;

  assign ce_present = ctrl[CTRL_CE_PRESENT_BIT];
  // Without a sense pin the pack is always in range
  assign temp_ok = pin.temp_ok || !ctrl[CTRL_TS_PRESENT_BIT];
  assign charge_en = !ce_present || !pin.charge_enable_n;

  always_comb
  begin
    next_state = state;
    next_por_cnt = '0;
    if (pin.below_powerdown)
      next_state = ST_POWER_DOWN;
    else if (!pin.input_detect)
      next_state = ST_SLEEP;
    else
    begin
      unique case (state)
        ST_POWER_DOWN, ST_SLEEP:
          next_state = ST_POR;
        ST_POR:
          if (por_cnt == POR_LAST)
            next_state = ce_present ? ST_STANDBY : ST_BEGIN;
          else
            next_por_cnt = por_cnt + 1'b1;
        ST_STANDBY:
          if (charge_en && pin.below_recharge && !pin.overvoltage)
            next_state = ST_BEGIN;
        ST_BEGIN:
          next_state = ST_CHARGING;
        ST_CHARGING, ST_SUSPEND:
          if (pin.overvoltage || !charge_en)
            next_state = ST_STANDBY;
          else
            next_state = temp_ok ? ST_CHARGING : ST_SUSPEND;
        default:
          next_state = ST_POWER_DOWN;
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      state <= ST_POWER_DOWN;
      por_cnt <= '0;
    end
    else
    begin
      state <= next_state;
      por_cnt <= next_por_cnt;
    end
  end

  // ---------------------------------------------------------------
  // Output controls
  // ---------------------------------------------------------------
  ctl_t next_ctl;
  logic regulator_only;
  logic term_on;
  logic done;

  assign regulator_only = pin.timer_pin_open;
  assign term_on = !pin.termination_enable_n && !regulator_only;
  // Done only exists while termination is enabled
  assign done = term_on && pin.termination_latched;

  always_comb
  begin
    next_ctl = CTL_RESET;
    next_ctl.term_detect_en = term_on;
    next_ctl.batt_detect_en = term_on;
    next_ctl.timer_reset = 1'b1;
    unique case (state)
      ST_POWER_DOWN, ST_SLEEP, ST_POR:
      begin
        next_ctl.term_detect_en = 1'b0;
        next_ctl.batt_detect_en = 1'b0;
      end
      ST_STANDBY:
        next_ctl.power_good_n_oe = !pin.overvoltage;
      ST_BEGIN:
      begin
        next_ctl.comparators_en = 1'b1;
        next_ctl.power_good_n_oe = !pin.overvoltage;
      end
      ST_CHARGING:
      begin
        next_ctl.power_good_n_oe = !pin.overvoltage;
        next_ctl.power_stage_on = !done;
        next_ctl.precharge_sel = pin.below_precharge;
        next_ctl.timer_reset = regulator_only;
        next_ctl.timer_run = !regulator_only;
        next_ctl.status_a_oe = !done;
        next_ctl.status_b_oe = done || pin.below_precharge;
      end
      ST_SUSPEND:
      begin
        next_ctl.power_good_n_oe = !pin.overvoltage;
        next_ctl.timer_reset = regulator_only;
        next_ctl.timer_hold = !regulator_only;
      end
      default:
        next_ctl.timer_reset = 1'b1;
    endcase
    next_ctl.comparators_en = state inside {ST_STANDBY, ST_BEGIN, ST_CHARGING, ST_SUSPEND};
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      O_CTL <= CTL_RESET;
    else
      O_CTL <= next_ctl;
  end

  // ---------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ---------------------------------------------------------------
  logic wr_pend;
  logic next_wr_pend;
  logic [7:0] wr_addr;
  logic [7:0] next_wr_addr;
  logic [1:0] next_ctrl;
  logic [31:0] next_rdata;
  logic take;

  assign take = I_HSEL && I_HTRANS[1] && I_HREADY;

  always_comb
  begin
    next_wr_pend = take && I_HWRITE;
    next_wr_addr = take ? I_HADDR[7:0] : wr_addr;
    next_ctrl = ctrl;
    next_rdata = O_HRDATA;
    if (wr_pend && wr_addr == CTRL_OFFSET)
      next_ctrl = I_HWDATA[1:0];
    if (take && !I_HWRITE)
    begin
      // Unmapped words read as zero
      next_rdata = '0;
      if (I_HADDR[7:0] == CTRL_OFFSET)
        next_rdata[1:0] = ctrl;
      else if (I_HADDR[7:0] == STATUS_OFFSET)
        next_rdata[11:0] = {O_CTL.power_stage_on, O_CTL.precharge_sel, regulator_only, pin.overvoltage,
                            temp_ok, pin.below_precharge, pin.input_detect, done, 1'b0, state};
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      ctrl <= CTRL_RESET;
      O_HRDATA <= '0;
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
    end
    else
    begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      ctrl <= next_ctrl;
      O_HRDATA <= next_rdata;
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_NRST);

  logic live;
  assign live = pin.input_detect && !pin.below_powerdown;

  a_pdown_all_off:
    assert property (state == ST_POWER_DOWN |=> !O_CTL.power_stage_on && !O_CTL.status_a_oe
                     && !O_CTL.status_b_oe && !O_CTL.power_good_n_oe)
    else $error("power-down left a pin or the stage on");
  a_sleep_on_loss:
    assert property (!pin.input_detect && !pin.below_powerdown |=> state == ST_SLEEP)
    else $error("lost input power did not give sleep");
  a_sleep_to_por:
    assert property (state == ST_SLEEP && live |=> state == ST_POR)
    else $error("sleep did not start the reset delay");
  a_por_quiet:
    assert property (state == ST_POR |=> !O_CTL.status_a_oe && !O_CTL.status_b_oe
                     && !O_CTL.power_good_n_oe && !O_CTL.comparators_en)
    else $error("pins active during reset delay");
  a_begin_to_charge:
    assert property (state == ST_BEGIN && live |=> state == ST_CHARGING ##1 !O_CTL.timer_hold)
    else $error("begin-charge did not move on");
  a_start_gate:
    assert property (state == ST_STANDBY ##1 state == ST_BEGIN |-> $past(pin.below_recharge)
                     && !$past(pin.overvoltage))
    else $error("charge began without its conditions");
  a_suspend_hold:
    assert property (state == ST_SUSPEND && !regulator_only |=> O_CTL.timer_hold
                     && !O_CTL.timer_reset && !O_CTL.power_stage_on)
    else $error("suspend did not hold the timers");
  a_open_timer_reset:
    assert property (regulator_only |=> O_CTL.timer_reset && !O_CTL.term_detect_en && !O_CTL.timer_run)
    else $error("open timer pin left timer running");
  a_precharge_pick:
    assert property (state == ST_CHARGING && pin.below_precharge |=> O_CTL.precharge_sel
                     && O_CTL.status_b_oe)
    else $error("precharge current not selected");
  a_ov_standby:
    assert property (state == ST_CHARGING && live && pin.overvoltage |=> state == ST_STANDBY
                     ##1 !O_CTL.power_stage_on && (!O_CTL.power_good_n_oe || !$past(pin.overvoltage)))
    else $error("overvoltage did not give standby");

  c_charging: cover property (state == ST_BEGIN ##1 state == ST_CHARGING);
  c_resume: cover property (state == ST_SUSPEND ##1 state == ST_CHARGING);
  c_done: cover property (state == ST_CHARGING && done);
  c_no_ce: cover property (state == ST_POR ##1 state == ST_BEGIN);

endmodule

`default_nettype wire

// *** charger_mode_controller_tb_top.sv ***
/*
 * Testbench for the charger mode controller: pin sequences and
 * AHB-Lite register accesses with expected levels.
 * Assumes the pin-side model and a 40 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module charger_mode_controller_tb_top;
  import charger_pkg::*;
  localparam int DLY = 40;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  pins_t p;
  pins_t dp;
  ctl_t ctl;
  logic ce_n = 1'b1;
  logic te_n = 1'b0;
  logic ce_w, te_w, sa, sb, pg;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready, hresp;
  logic [31:0] r;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  always_comb
  begin
    dp = p;
    dp.charge_enable_n = ce_w;
    dp.termination_enable_n = te_w;
  end
  charger_mode_controller #(.POR_DELAY(DLY)) u_dut (.I_REF_CLK(clk), .I_NRST(nrst), .I_PINS(dp),
    .O_CTL(ctl), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
    .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
    .O_HREADYOUT(hready), .O_HRESP(hresp));
  charger_pin_host u_host (.i_ctl(ctl), .i_ce_n(ce_n), .i_te_n(te_n), .o_ce_n(ce_w),
    .o_te_n(te_w), .o_stat_a(sa), .o_stat_b(sb), .o_pg_n(pg));
  task finish_test;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fails++;
      finish_test;
    end
  end
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask
  // Let the pin change cross the synchroniser, then look at state and pins
  task lv(input logic [2:0] s, input logic a, input logic b, input logic g);
    repeat (6) @(posedge clk);
    ahb(1'b0, 32'h4, 32'h0, r);
    `CHK("state", s, r[2:0])
    `CHK("stat_a", a, sa)
    `CHK("stat_b", b, sb)
    `CHK("pg_n", g, pg)
  endtask
  initial
  begin
    p = '0;
    p.below_powerdown = 1'b1;
    p.temp_ok = 1'b1;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    lv(3'h0, 1'b1, 1'b1, 1'b1);
    `CHK("stage", 1'b0, ctl.power_stage_on)
    p.below_powerdown <= 1'b0;
    lv(3'h1, 1'b1, 1'b1, 1'b1);
    p.input_detect <= 1'b1;
    lv(3'h3, 1'b1, 1'b1, 1'b1);
    `CHK("cmp_en", 1'b0, ctl.comparators_en)
    repeat (DLY) @(posedge clk);
    lv(3'h2, 1'b1, 1'b1, 1'b0);
    `CHK("cmp_en", 1'b1, ctl.comparators_en)
    `CHK("tmr_rst", 1'b1, ctl.timer_reset)
    ce_n <= 1'b0;
    p.below_recharge <= 1'b1;
    p.below_precharge <= 1'b1;
    lv(3'h7, 1'b0, 1'b0, 1'b0);
    `CHK("stage", 1'b1, ctl.power_stage_on)
    `CHK("tmr_run", 1'b1, ctl.timer_run)
    `CHK("pre_sel", 1'b1, ctl.precharge_sel)
    p.below_precharge <= 1'b0;
    lv(3'h7, 1'b0, 1'b1, 1'b0);
    `CHK("pre_sel", 1'b0, ctl.precharge_sel)
    p.temp_ok <= 1'b0;
    lv(3'h5, 1'b1, 1'b1, 1'b0);
    `CHK("tmr_hold", 1'b1, ctl.timer_hold)
    `CHK("tmr_rst", 1'b0, ctl.timer_reset)
    p.temp_ok <= 1'b1;
    lv(3'h7, 1'b0, 1'b1, 1'b0);
    `CHK("tmr_rst", 1'b0, ctl.timer_reset)
    p.termination_latched <= 1'b1;
    lv(3'h7, 1'b1, 1'b0, 1'b0);
    `CHK("stage", 1'b0, ctl.power_stage_on)
    te_n <= 1'b1;
    lv(3'h7, 1'b0, 1'b1, 1'b0);
    `CHK("term_en", 1'b0, ctl.term_detect_en)
    te_n <= 1'b0;
    p.timer_pin_open <= 1'b1;
    lv(3'h7, 1'b0, 1'b1, 1'b0);
    `CHK("tmr_rst", 1'b1, ctl.timer_reset)
    `CHK("batt_en", 1'b0, ctl.batt_detect_en)
    p.timer_pin_open <= 1'b0;
    p.termination_latched <= 1'b0;
    p.overvoltage <= 1'b1;
    lv(3'h2, 1'b1, 1'b1, 1'b1);
    p.overvoltage <= 1'b0;
    lv(3'h7, 1'b0, 1'b1, 1'b0);
    p.input_detect <= 1'b0;
    lv(3'h1, 1'b1, 1'b1, 1'b1);
    // Variant without the enable pin
    ahb(1'b1, 32'h0, 32'h2, r);
    ahb(1'b0, 32'h0, 32'h0, r);
    `CHK("ctrl", 2'h2, r[1:0])
    ahb(1'b0, 32'h10, 32'h0, r);
    `CHK("unmapped", 32'h0, r)
    ce_n <= 1'b1;
    p.input_detect <= 1'b1;
    lv(3'h3, 1'b1, 1'b1, 1'b1);
    repeat (DLY) @(posedge clk);
    lv(3'h7, 1'b0, 1'b1, 1'b0);
    // Mid-run reset floats every pin and restores the straps
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("ctl_rst", CTL_RESET, ctl)
    nrst <= 1'b1;
    @(posedge clk);
    ahb(1'b0, 32'h0, 32'h0, r);
    `CHK("ctrl_rst", CTRL_RESET, r[1:0])
    finish_test;
  end
endmodule
`default_nettype wire

// *** charger_pin_host.sv ***
/*
 * Pin-side model: host driving the two enable pins, pull-ups on the
 * open-collector status and power-good pins.
 * Assumes the pin data bits are low and the enables pull the pin down.
 */
`timescale 1ns/100ps
`default_nettype none
module charger_pin_host (
  // Controller outputs
  input wire charger_pkg::ctl_t i_ctl,
  // Host requests
  input wire logic i_ce_n,
  input wire logic i_te_n,
  // Pin levels
  output logic o_ce_n,
  output logic o_te_n,
  output logic o_stat_a,
  output logic o_stat_b,
  output logic o_pg_n
);
  import charger_pkg::*;
  // Host selects both enable levels
  assign o_ce_n = i_ce_n;
  assign o_te_n = i_te_n;
  // Pull-ups win whenever the pin floats
  assign o_stat_a = i_ctl.status_a_oe ? i_ctl.status_a : 1'b1;
  assign o_stat_b = i_ctl.status_b_oe ? i_ctl.status_b : 1'b1;
  assign o_pg_n = i_ctl.power_good_n_oe ? i_ctl.power_good_n : 1'b1;
endmodule
`default_nettype wire

// *** charger_pkg.sv ***
/*
 * Shared constants and types for the charger mode controller:
 * state codes, pin and control bundles, register map, timing.
 * Assumes a 40 MHz logic clock and a word-wide AHB-Lite register bus.
 */
`default_nettype none

package charger_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int POR_TIME_US = 1000;
  // Least time, so round up
  localparam int POR_CYCLES = (POR_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam int CTRL_CE_PRESENT_BIT = 0;
  localparam int CTRL_TS_PRESENT_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POWER_DOWN = 3'h0,
    ST_SLEEP = 3'h1,
    ST_POR = 3'h3,
    ST_STANDBY = 3'h2,
    ST_BEGIN = 3'h6,
    ST_CHARGING = 3'h7,
    ST_SUSPEND = 3'h5
  } state_t;

  // Comparator results and control pin levels, all asynchronous
  typedef struct packed {
    logic below_powerdown;
    logic input_detect;
    logic overvoltage;
    logic charge_enable_n;
    logic termination_enable_n;
    logic below_recharge;
    logic below_precharge;
    logic temp_ok;
    logic timer_pin_open;
    logic termination_latched;
  } pins_t;

  // Controls to the analog stages and open-collector pins
  typedef struct packed {
    logic power_stage_on;
    logic precharge_sel;
    logic timer_reset;
    logic timer_hold;
    logic timer_run;
    logic term_detect_en;
    logic batt_detect_en;
    logic comparators_en;
    logic status_a;
    logic status_a_oe;
    logic status_b;
    logic status_b_oe;
    logic power_good_n;
    logic power_good_n_oe;
  } ctl_t;

  localparam ctl_t CTL_RESET = '0;

endpackage

`default_nettype wire
